// ==== hw/osd_cmd_regs.vh ====
// Constants for the serial command decoder of the video overlay controller.
// Assumes a 100 MHz system clock; included by the sync monitor and decoder files.
// Summary of operation
// - Commands arrive as serial bytes, ID then data
// - Last command ID applies to later data bytes
// - Serial enable high selects address set command
// - System reset clears every command-held field
// - Row from byte one, column from byte two
// - Character byte: 7-bit code plus flash flag
// - Character mode holds until serial enable high
// - Bit 7 clear marks data, set marks ID
// - Vertical start is line period times 2*field
// - Crystal rate bit picks 2x or 4x subcarrier
// - Horizontal start is two dots per step
// - Dot clock source bit picks LC or crystal
// - Soft reset clears registers, display off
// - Erase bit fills memory with 7fh slowly
// - Oscillator halt allowed only when bit set
// - Blinking reverse characters alternate, never blank
// - Blink period bit picks 0.5 s or 1.0 s
// - Blanking off, border or full, content select
// - Backdrop colour off gives plain background level
// - Burst off suppresses colour burst
// - Mute cuts input video, pedestal output
// - Pin modes select sync or overlay signals
// - Sync lost after selected count of missing lines
// - Sync present after selected count of found lines
// - Port bits force sync pins to static levels
`ifndef OSD_CMD_REGS_VH
`define OSD_CMD_REGS_VH
// Command identities, taken from byte one bits 6..4
`define CMD_ADDRESS_SET 3'h0
`define CMD_CHAR_WRITE 3'h1
`define CMD_VERTICAL 3'h2
`define CMD_HORIZONTAL 3'h3
`define CMD_DISPLAY 3'h4
`define CMD_STANDARD 3'h5
`define CMD_SYNC 3'h6
`define CMD_PORT 3'h7
// Field positions
`define ID_BIT 7
`define SOFT_RESET_BIT 0
`define OSC_HALT_BIT 1
`define MEM_CLEAR_BIT 2
`define TEST_BIT 3
`define CRYSTAL_RATE_BIT 6
`define DOT_SRC_BIT 6
`define OVERLAY_BIT 0
`define REVERSE_BIT 1
`define BLINK_EN_BIT 2
`define BLINK_PER_BIT 3
`define FULL_CONTENT_BIT 6
`define INTERNAL_SYNC_BIT 0
`define NONINTERLACE_BIT 1
`define BURST_OFF_BIT 3
`define BACKDROP_OFF_BIT 4
`define MUTE_BIT 0
`define ROW_COUNT_BIT 1
`define SYNC_MODE_BIT 2
`define SEP_MODE_BIT 3
`define LEVEL_A_BIT 0
`define OVERRIDE_A_BIT 1
`define LEVEL_B_BIT 2
`define OVERRIDE_B_BIT 3
// Reset value of every held field
`define REG_RESET 8'h00
// Display geometry and erase fill code
`define ROWS 12
`define COLUMNS 24
`define LAST_ROW 4'hb
`define LAST_COL 5'h17
`define ERASE_CODE 8'h7f
// Timing: nominal figures, then cycles at the clock rate
`define CLK_KHZ 100000
`define ERASE_TIME_US 500
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_KHZ / 1000)
`define BLINK_SHORT_MS 500
`define BLINK_HALF_CYCLES (`BLINK_SHORT_MS * `CLK_KHZ / 2)
`define LINE_TIME_US 64
`define LINE_CYCLES (`LINE_TIME_US * `CLK_KHZ / 1000)
`endif

// ==== hw/glyph_ram.v ====
// Display memory: one word per character cell, registered read port.
// Assumes writer and reader share the system clock.
`timescale 1ns/1ps
module glyph_ram #(
  parameter DEPTH = 288,
  parameter AW = 9
) (
  // Clock
  input wire i_ref_clk,
  // Write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [7:0] i_wdata,
  // Read port
  input wire [AW-1:0] i_raddr,
  output reg [7:0] o_rdata
);
  reg [7:0] mem [0:DEPTH-1];

  // Write and registered read; contents are not reset, erase fills them
  always @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // glyph_ram

// ==== hw/sync_monitor.v ====
// Sync presence monitor with line-counted hysteresis.
// Assumes i_sync_edge is a one-cycle pulse already in the clock domain.
`timescale 1ns/1ps
`include "osd_cmd_regs.vh"
module sync_monitor #(
  parameter LINE_CYCLES = `LINE_CYCLES
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // Control
  input wire [3:0] i_loss_sel,
  input wire [2:0] i_acq_sel,
  input wire i_sync_edge,
  // Status
  output reg o_present
);
  reg [31:0] line_cnt_r;
  reg seen_r;
  reg [8:0] run_r;
  reg [8:0] loss_need;
  reg [8:0] acq_need;
  wire line_end = (line_cnt_r == LINE_CYCLES - 1);

  // Count needed for each selection; unknown loss codes disable the loss check, unknown acquire codes acquire after one line
  always @* begin
    case (i_loss_sel)
      4'h1: loss_need = 9'h020;
      4'h2: loss_need = 9'h040;
      4'h4: loss_need = 9'h080;
      4'h8: loss_need = 9'h100;
      default: loss_need = 9'h000;
    endcase
    case (i_acq_sel)
      3'h1: acq_need = 9'h004;
      3'h2: acq_need = 9'h008;
      3'h4: acq_need = 9'h010;
      default: acq_need = 9'h000;
    endcase
  end

  // One sample per line period; run counts lines against current state
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      line_cnt_r <= 32'h0;
      seen_r <= 1'b0;
      run_r <= 9'h0;
      o_present <= 1'b0;
    end else begin
      line_cnt_r <= line_end ? 32'h0 : line_cnt_r + 32'h1;
      seen_r <= line_end ? 1'b0 : (seen_r | i_sync_edge);
      if (line_end) begin
        if (o_present == (seen_r | i_sync_edge)) begin
          run_r <= 9'h0;
        end else if (!o_present) begin
          if (run_r + 9'h1 >= acq_need) begin
            o_present <= 1'b1;
            run_r <= 9'h0;
          end else begin
            run_r <= run_r + 9'h1;
          end
        end else if (loss_need != 9'h000) begin
          if (run_r + 9'h1 >= loss_need) begin
            o_present <= 1'b0;
            run_r <= 9'h0;
          end else begin
            run_r <= run_r + 9'h1;
          end
        end
      end
    end
  end
endmodule // sync_monitor

// ==== hw/osd_cmd_decoder.v ====
// Serial command decoder: shifts in command bytes, holds control fields,
// writes display memory and drives the sync output pins.
// Assumes the raster pipeline supplies sync and overlay levels on i_ref_clk.
`timescale 1ns/1ps
`include "osd_cmd_regs.vh"
module osd_cmd_decoder #(
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES,
  parameter LINE_CYCLES = `LINE_CYCLES
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // Serial command pins
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_serial_in,
  // Sync pin and raster levels
  input wire i_sync_in,
  input wire i_csync_gen,
  input wire i_char_border,
  // Raster read of display memory
  input wire [8:0] i_rd_addr,
  output wire [7:0] o_rd_data,
  // Geometry
  output reg [6:0] o_vert_start_lines,
  output reg [6:0] o_horiz_start_dots,
  output reg [1:0] o_height_a,
  output reg [1:0] o_height_b,
  output reg [1:0] o_width_a,
  output reg [1:0] o_width_b,
  // Clocking
  output reg o_crystal_rate_select,
  output reg o_dot_clock_source,
  output reg o_oscillator_halt_allow,
  // Display control
  output reg o_overlay_enable,
  output reg o_reverse_video,
  output reg o_factory_test,
  output reg o_blink_hide,
  output reg o_blink_invert,
  output reg [1:0] o_blanking_area_select,
  output reg o_full_blank_content,
  output reg o_erase_busy,
  // Standard and colour
  output reg o_internal_sync,
  output reg o_non_interlaced,
  output reg [1:0] o_tv_standard_select,
  output reg o_row_count_select,
  output reg [2:0] o_backdrop_phase,
  output reg o_backdrop_color_off,
  output reg o_burst_off,
  output reg o_video_mute,
  // Sync pins
  output reg o_composite_sync_pin,
  output reg o_separated_sync_pin,
  output wire o_sync_detect
);
  // Pin synchronisers; stage one feeds only stage two
  reg [1:0] cs_s_r, sclk_s_r, sin_s_r, sync_s_r;
  reg sclk_d_r, sync_d_r;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cs_s_r <= 2'h3;
      sclk_s_r <= 2'h3;
      sin_s_r <= 2'h3;
      sync_s_r <= 2'h0;
      sclk_d_r <= 1'b1;
      sync_d_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[0], i_cs_n};
      sclk_s_r <= {sclk_s_r[0], i_sclk};
      sin_s_r <= {sin_s_r[0], i_serial_in};
      sync_s_r <= {sync_s_r[0], i_sync_in};
      sclk_d_r <= sclk_s_r[1];
      sync_d_r <= sync_s_r[1];
    end
  end
  wire cs_hi = cs_s_r[1];
  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sync_rise = sync_s_r[1] & ~sync_d_r;

  // Held command state
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg [2:0] cmd_r;
  reg char_mode_r;
  reg [3:0] row_r;
  reg [4:0] col_r;
  reg [7:0] vsize_r, vpos_r, hsize_r, hpos_r;
  reg [7:0] sys_r, attr_r, std_r, color_r, syncout_r, detect_r, port_r;
  reg [8:0] erase_addr_r;
  reg [31:0] erase_tmr_r;

  // Size code to 1..3 units; all-ones falls back to one
  function [1:0] size_units;
    input [1:0] code;
    begin
      size_units = (code == 2'h3) ? 2'h1 : code + 2'h1;
    end
  endfunction

  // Cell index from row and column
  function [8:0] cell_index;
    input [3:0] row;
    input [4:0] col;
    begin
      cell_index = row * 9'h018 + {4'h0, col};
    end
  endfunction

  // Byte assembly, MSB first; a frame boundary restarts the byte
  wire [7:0] byte_in = {shift_r[6:0], sin_s_r[1]};
  wire byte_done = ~cs_hi & sclk_rise & (bit_cnt_r == 3'h7);
  wire is_id = byte_in[`ID_BIT];
  wire [2:0] id_code = byte_in[6:4];
  wire char_write = byte_done & char_mode_r;
  wire soft_rst = byte_done & ~char_mode_r & is_id & (id_code == `CMD_DISPLAY)
    & byte_in[`SOFT_RESET_BIT];
  wire erase_start = byte_done & ~char_mode_r & is_id & (id_code == `CMD_DISPLAY)
    & byte_in[`MEM_CLEAR_BIT];
  localparam [31:0] ERASE_STEP = ERASE_CYCLES / 288;
  wire erase_tick = o_erase_busy & (erase_tmr_r >= ERASE_STEP - 1);

  // Shift register and frame tracking
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      shift_r <= `REG_RESET;
      bit_cnt_r <= 3'h0;
    end else if (cs_hi) begin
      bit_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      shift_r <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Command interpretation and held fields
  always @(posedge i_ref_clk) begin
    if (!i_rst_n || soft_rst) begin
      cmd_r <= `CMD_ADDRESS_SET;
      char_mode_r <= 1'b0;
      row_r <= 4'h0;
      col_r <= 5'h0;
      vsize_r <= `REG_RESET;
      vpos_r <= `REG_RESET;
      hsize_r <= `REG_RESET;
      hpos_r <= `REG_RESET;
      sys_r <= `REG_RESET;
      attr_r <= `REG_RESET;
      std_r <= `REG_RESET;
      color_r <= `REG_RESET;
      syncout_r <= `REG_RESET;
      detect_r <= `REG_RESET;
      port_r <= `REG_RESET;
    end else if (cs_hi) begin
      cmd_r <= `CMD_ADDRESS_SET;
      char_mode_r <= 1'b0;
    end else if (char_write) begin
      // Consecutive bytes fill consecutive cells, wrapping row by row
      if (col_r == `LAST_COL) begin
        col_r <= 5'h0;
        row_r <= (row_r == `LAST_ROW) ? 4'h0 : row_r + 4'h1;
      end else begin
        col_r <= col_r + 5'h1;
      end
    end else if (byte_done && is_id) begin
      cmd_r <= id_code;
      char_mode_r <= (id_code == `CMD_CHAR_WRITE);
      case (id_code)
        `CMD_ADDRESS_SET: row_r <= byte_in[3:0];
        `CMD_VERTICAL: vsize_r <= byte_in;
        `CMD_HORIZONTAL: hsize_r <= byte_in;
        `CMD_DISPLAY: sys_r <= {byte_in[7:3], 3'h0} | {6'h0, byte_in[1], 1'b0};
        `CMD_STANDARD: std_r <= byte_in;
        `CMD_SYNC: syncout_r <= byte_in;
        `CMD_PORT: port_r <= byte_in;
        default: ;
      endcase
    end else if (byte_done) begin
      // Data byte: applies to the command last identified
      case (cmd_r)
        `CMD_ADDRESS_SET: col_r <= byte_in[4:0];
        `CMD_VERTICAL: vpos_r <= byte_in;
        `CMD_HORIZONTAL: hpos_r <= byte_in;
        `CMD_DISPLAY: attr_r <= byte_in;
        `CMD_STANDARD: color_r <= byte_in;
        `CMD_SYNC: detect_r <= byte_in;
        default: ;
      endcase
    end
  end

  // Erase sequencer, paced so the whole fill spans the erase time
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_erase_busy <= 1'b0;
      erase_addr_r <= 9'h0;
      erase_tmr_r <= 32'h0;
    end else if (erase_start) begin
      o_erase_busy <= 1'b1;
      erase_addr_r <= 9'h0;
      erase_tmr_r <= 32'h0;
    end else if (o_erase_busy) begin
      erase_tmr_r <= erase_tick ? 32'h0 : erase_tmr_r + 32'h1;
      if (erase_tick) begin
        erase_addr_r <= erase_addr_r + 9'h1;
        if (erase_addr_r == 9'h11f) begin
          o_erase_busy <= 1'b0;
        end
      end
    end
  end

  // Memory write: erase owns the port, character writes then are dropped
  wire mem_we = erase_tick | (char_write & ~o_erase_busy);
  wire [8:0] mem_addr = o_erase_busy ? erase_addr_r : cell_index(row_r, col_r);
  wire [7:0] mem_data = o_erase_busy ? `ERASE_CODE : byte_in;

  glyph_ram #(
    .DEPTH(`ROWS * `COLUMNS),
    .AW(9)
  ) u_ram (
    .i_ref_clk(i_ref_clk),
    .i_we(mem_we),
    .i_waddr(mem_addr),
    .i_wdata(mem_data),
    .i_raddr(i_rd_addr),
    .o_rdata(o_rd_data)
  );

  sync_monitor #(
    .LINE_CYCLES(LINE_CYCLES)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_loss_sel(detect_r[3:0]),
    .i_acq_sel(detect_r[6:4]),
    .i_sync_edge(sync_rise),
    .o_present(o_sync_detect)
  );

  // Blink timer; toggles twice per period, long period doubles the count
  reg [31:0] blink_tmr_r;
  reg blink_phase_r;
  wire [31:0] blink_limit = attr_r[`BLINK_PER_BIT] ?
    BLINK_HALF_CYCLES * 2 - 1 : BLINK_HALF_CYCLES - 1;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      blink_tmr_r <= 32'h0;
      blink_phase_r <= 1'b0;
    end else if (blink_tmr_r >= blink_limit) begin
      blink_tmr_r <= 32'h0;
      blink_phase_r <= ~blink_phase_r;
    end else begin
      blink_tmr_r <= blink_tmr_r + 32'h1;
    end
  end

  // Registered field outputs
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_vert_start_lines <= 7'h0;
      o_horiz_start_dots <= 7'h0;
      o_height_a <= 2'h1;
      o_height_b <= 2'h1;
      o_width_a <= 2'h1;
      o_width_b <= 2'h1;
      o_crystal_rate_select <= 1'b0;
      o_dot_clock_source <= 1'b0;
      o_oscillator_halt_allow <= 1'b0;
      o_overlay_enable <= 1'b0;
      o_reverse_video <= 1'b0;
      o_factory_test <= 1'b0;
      o_blink_hide <= 1'b0;
      o_blink_invert <= 1'b0;
      o_blanking_area_select <= 2'h0;
      o_full_blank_content <= 1'b0;
      o_internal_sync <= 1'b0;
      o_non_interlaced <= 1'b0;
      o_tv_standard_select <= 2'h0;
      o_row_count_select <= 1'b0;
      o_backdrop_phase <= 3'h0;
      o_backdrop_color_off <= 1'b0;
      o_burst_off <= 1'b0;
      o_video_mute <= 1'b0;
    end else begin
      o_vert_start_lines <= {vpos_r[5:0], 1'b0};
      o_horiz_start_dots <= {hpos_r[5:0], 1'b0};
      o_height_a <= size_units(vsize_r[1:0]);
      o_height_b <= size_units(vsize_r[3:2]);
      o_width_a <= size_units(hsize_r[1:0]);
      o_width_b <= size_units(hsize_r[3:2]);
      o_crystal_rate_select <= vpos_r[`CRYSTAL_RATE_BIT];
      o_dot_clock_source <= hpos_r[`DOT_SRC_BIT];
      o_oscillator_halt_allow <= sys_r[`OSC_HALT_BIT];
      o_overlay_enable <= attr_r[`OVERLAY_BIT];
      o_reverse_video <= attr_r[`REVERSE_BIT];
      o_factory_test <= sys_r[`TEST_BIT];
      // Reverse glyphs flip polarity instead of vanishing
      o_blink_hide <= attr_r[`BLINK_EN_BIT] & blink_phase_r & ~attr_r[`REVERSE_BIT];
      o_blink_invert <= attr_r[`BLINK_EN_BIT] & blink_phase_r & attr_r[`REVERSE_BIT];
      o_blanking_area_select <= attr_r[5:4];
      o_full_blank_content <= attr_r[`FULL_CONTENT_BIT];
      o_internal_sync <= std_r[`INTERNAL_SYNC_BIT];
      o_non_interlaced <= std_r[`NONINTERLACE_BIT];
      o_tv_standard_select <= std_r[3:2];
      o_row_count_select <= syncout_r[`ROW_COUNT_BIT];
      o_backdrop_phase <= color_r[2:0];
      o_backdrop_color_off <= color_r[`BACKDROP_OFF_BIT];
      o_burst_off <= color_r[`BURST_OFF_BIT];
      o_video_mute <= syncout_r[`MUTE_BIT];
    end
  end

  // Sync pin selection, then port override on top
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_composite_sync_pin <= 1'b0;
      o_separated_sync_pin <= 1'b0;
    end else begin
      if (port_r[`OVERRIDE_A_BIT]) begin
        o_composite_sync_pin <= port_r[`LEVEL_A_BIT];
      end else if (syncout_r[`SYNC_MODE_BIT]) begin
        o_composite_sync_pin <= i_char_border;
      end else begin
        o_composite_sync_pin <= i_csync_gen;
      end
      if (port_r[`OVERRIDE_B_BIT]) begin
        o_separated_sync_pin <= port_r[`LEVEL_B_BIT];
      end else if (syncout_r[`SEP_MODE_BIT] && std_r[`INTERNAL_SYNC_BIT]) begin
        o_separated_sync_pin <= 1'b1;
      end else begin
        o_separated_sync_pin <= sync_s_r[1];
      end
    end
  end
endmodule // osd_cmd_decoder

// ==== testbench/host_serial_model.sv ====
// Host side of the three-wire command link: frames of serial bytes.
// Assumes the caller hands over whole bytes; lines idle high (pull-ups).
`timescale 1ns/1ps
module host_serial_model (
  // Serial pins toward the decoder
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdata
);
  // Pull-ups hold every pin high between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdata = 1'b1;
  end

  // One frame: select, bytes MSB first, hold, deselect
  task automatic frame(input logic [7:0] q[$]);
    o_cs_n = 1'b0;
    #200;
    foreach (q[k]) begin
      for (int b = 7; b >= 0; b--) begin
        o_sclk = 1'b0;
        o_sdata = q[k][b];
        #80 o_sclk = 1'b1;
        #80;
      end
      // Data released to the pull-up; pad to the minimum word time
      #120 o_sdata = 1'b1;
      #2800;
    end
    #2000 o_cs_n = 1'b1;
    #1000;
  endtask
endmodule // host_serial_model

// ==== testbench/osd_cmd_checker_assertions.sv ====
// Checker: timing relations at the command decoder's ports.
// Assumes a bind into osd_cmd_decoder; one clock domain.
`timescale 1ns/1ps
module osd_cmd_checker #(
  parameter ERASE_CYCLES = 576,
  parameter LINE_CYCLES = 20
) (
  // Clock, reset and pins
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_cs_n,
  input wire i_sync_in,
  // Watched outputs
  input wire [6:0] o_vert_start_lines,
  input wire [6:0] o_horiz_start_dots,
  input wire [1:0] o_height_a,
  input wire [1:0] o_height_b,
  input wire [1:0] o_width_a,
  input wire [1:0] o_width_b,
  input wire o_overlay_enable,
  input wire o_reverse_video,
  input wire o_blink_hide,
  input wire o_blink_invert,
  input wire o_erase_busy,
  input wire o_composite_sync_pin,
  input wire o_sync_detect
);
  int unsigned erase_cnt_r;
  int unsigned quiet_cnt_r;
  logic sync_d_r;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Busy length and time since the last raw sync edge
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      erase_cnt_r <= 0;
      quiet_cnt_r <= 0;
    end else begin
      erase_cnt_r <= o_erase_busy ? erase_cnt_r + 1 : 0;
      quiet_cnt_r <= (i_sync_in && !sync_d_r) ? 0 : quiet_cnt_r + 1;
    end
    sync_d_r <= i_sync_in;
  end

  property p_reset_clear;
    $rose(i_rst_n) |-> o_vert_start_lines == 7'h00 && o_height_a == 2'h1
      && o_width_b == 2'h1 && !o_overlay_enable && !o_composite_sync_pin;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset fields");
  property p_vstart_even;
    o_vert_start_lines[0] == 1'b0;
  endproperty
  a_vstart_even: assert property (p_vstart_even) else $error("odd vstart");
  property p_hstart_even;
    o_horiz_start_dots[0] == 1'b0;
  endproperty
  a_hstart_even: assert property (p_hstart_even) else $error("odd hstart");
  property p_size_range;
    o_height_a != 2'h0 && o_height_b != 2'h0 && o_width_a != 2'h0 && o_width_b != 2'h0;
  endproperty
  a_size_range: assert property (p_size_range) else $error("size zero");
  property p_blink_excl;
    !(o_blink_hide && o_blink_invert);
  endproperty
  a_blink_excl: assert property (p_blink_excl) else $error("blink both");
  property p_blink_rv;
    o_blink_invert |-> o_reverse_video || $past(o_reverse_video);
  endproperty
  a_blink_rv: assert property (p_blink_rv) else $error("invert without rv");
  property p_idle_hold;
    i_cs_n [*8] |=> $stable({o_vert_start_lines, o_horiz_start_dots, o_overlay_enable});
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("field moved idle");
  property p_erase_bound;
    erase_cnt_r <= ERASE_CYCLES + 8;
  endproperty
  a_erase_bound: assert property (p_erase_bound) else $error("erase long");
  property p_erase_len;
    $fell(o_erase_busy) |-> erase_cnt_r >= ERASE_CYCLES - 8;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase short");
  property p_loss_quiet;
    $fell(o_sync_detect) |-> quiet_cnt_r >= 31 * LINE_CYCLES;
  endproperty
  a_loss_quiet: assert property (p_loss_quiet) else $error("sync lost early");
endmodule // osd_cmd_checker

bind osd_cmd_decoder osd_cmd_checker #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .LINE_CYCLES(LINE_CYCLES)
) osd_cmd_checker_inst (
  .i_ref_clk, .i_rst_n, .i_cs_n, .i_sync_in, .o_vert_start_lines,
  .o_horiz_start_dots, .o_height_a, .o_height_b, .o_width_a, .o_width_b,
  .o_overlay_enable, .o_reverse_video, .o_blink_hide, .o_blink_invert,
  .o_erase_busy, .o_composite_sync_pin, .o_sync_detect
);

// ==== testbench/testbench.sv ====
// Testbench: serial commands via the host model, fields checked at ports.
// Assumes shortened erase, blink and line counts set below.
`timescale 1ns/1ps
module testbench;
  logic i_ref_clk, i_rst_n, i_csync_gen, i_char_border;
  logic i_sync_in = 1'b0;
  logic [8:0] i_rd_addr;
  wire i_cs_n, i_sclk, i_serial_in;
  wire [7:0] o_rd_data;
  wire [6:0] o_vert_start_lines, o_horiz_start_dots;
  wire [1:0] o_height_a, o_height_b, o_width_a, o_width_b;
  wire [1:0] o_blanking_area_select, o_tv_standard_select;
  wire [2:0] o_backdrop_phase;
  wire o_crystal_rate_select, o_dot_clock_source, o_oscillator_halt_allow;
  wire o_overlay_enable, o_reverse_video, o_factory_test, o_blink_hide;
  wire o_blink_invert, o_full_blank_content, o_erase_busy, o_internal_sync;
  wire o_non_interlaced, o_row_count_select, o_backdrop_color_off, o_burst_off;
  wire o_video_mute, o_composite_sync_pin, o_separated_sync_pin, o_sync_detect;
  wire [15:0] grp [0:4];
  logic [7:0] fq[$];
  logic sync_on = 1'b0;
  logic sin_lvl = 1'b0;
  int lc = 0;
  int cyc = 0;
  int n;
  int bad_count = 0;
  int cmp_count = 0;
  // Rows: id byte, data byte, group, expected group value
  localparam logic [39:0] ROWS [11] = '{
    40'had_7f_00_687e,
    40'ha2_00_00_7000,
    40'hb6_01_01_b002,
    40'hb0_40_01_5800,
    40'hca_63_02_c063,
    40'hc0_11_02_0011,
    40'hd7_1d_03_071d,
    40'hd8_00_03_0800,
    40'hdc_08_03_0c08,
    40'he3_00_04_0003,
    40'hc1_00_01_5000};

  osd_cmd_decoder #(.ERASE_CYCLES(576), .BLINK_HALF_CYCLES(8), .LINE_CYCLES(20))
    osd_cmd_decoder_inst (.*);
  host_serial_model host_serial_model_inst (.o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_sdata(i_serial_in));

  // Observed fields packed in the layout of their command bytes
  assign grp[0] = {o_height_b, o_height_a, o_crystal_rate_select, 4'h0, o_vert_start_lines};
  assign grp[1] = {o_width_b, o_width_a, o_dot_clock_source, 4'h0, o_horiz_start_dots};
  assign grp[2] = {o_factory_test, o_oscillator_halt_allow, 7'h00, o_full_blank_content,
    o_blanking_area_select, 2'h0, o_reverse_video, o_overlay_enable};
  assign grp[3] = {4'h0, o_tv_standard_select, o_non_interlaced, o_internal_sync, 3'h0,
    o_backdrop_color_off, o_burst_off, o_backdrop_phase};
  assign grp[4] = {14'h0, o_row_count_select, o_video_mute};

  // Free-running system clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // One sync pulse per line, or a static level for the pin cases
  always @(negedge i_ref_clk) begin
    lc <= (lc == 19) ? 0 : lc + 1;
    i_sync_in <= sync_on ? (lc == 0) : sin_lvl;
  end

  // Hang guard: roughly twice the expected run length
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
    cmp_count++;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic settle();
    repeat (10) @(negedge i_ref_clk);
  endtask

  task automatic send(input logic [7:0] q[$]);
    host_serial_model_inst.frame(q);
    settle();
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    i_rd_addr = a;
    @(negedge i_ref_clk);
    chk("memory", {8'h00, e}, {8'h00, o_rd_data});
  endtask

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    @(negedge i_ref_clk);
    for (int g = 0; g < 5; g++) chk("reset group", g < 2 ? 16'h5000 : 16'h0, grp[g]);
    chk("reset pins", 16'h0, {13'h0, o_composite_sync_pin, o_separated_sync_pin,
      o_sync_detect});
    settle();
  endtask

  // Counts phase toggles of the selected blink output; the other stays low
  task automatic blink(input logic [7:0] b2, input int lo, input int hi);
    int t;
    int w;
    logic p;
    logic s;
    send('{8'hc0, b2});
    t = 0;
    w = 0;
    p = 1'b0;
    repeat (128) begin
      @(negedge i_ref_clk);
      s = b2[1] ? o_blink_invert : o_blink_hide;
      t += (s !== p);
      w += ((b2[1] ? o_blink_hide : o_blink_invert) !== 1'b0);
      p = s;
    end
    chk("blink toggles", 16'h1, {15'h0, t >= lo && t <= hi});
    chk("blink other", 16'h0, w[15:0]);
  endtask

  task automatic pin(input logic [7:0] b1, input logic [2:0] lv, input logic [1:0] e);
    {i_csync_gen, i_char_border, sin_lvl} = lv;
    send('{b1});
    chk("sync pins", {14'h0, e}, {14'h0, o_composite_sync_pin, o_separated_sync_pin});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_csync_gen = 1'b0;
    i_char_border = 1'b0;
    i_rd_addr = 9'h000;
    do_reset();
    // Character mode, row wrap, flag bit kept as data
    send('{8'h85, 8'h16, 8'h90, 8'h41, 8'hc2, 8'h7f});
    rd(9'h08e, 8'h41);
    rd(9'h08f, 8'hc2);
    rd(9'h090, 8'h7f);
    send('{8'h03, 8'h90, 8'h55});
    rd(9'h093, 8'h55);
    // Memory erase, busy counted while the frame runs
    n = 0;
    fq = '{8'hc4};
    fork
      host_serial_model_inst.frame(fq);
      repeat (1200) begin
        @(negedge i_ref_clk);
        n += (o_erase_busy === 1'b1);
      end
    join
    chk("erase time", 16'h1, {15'h0, n >= 570 && n <= 582});
    rd(9'h000, 8'h7f);
    rd(9'h11f, 8'h7f);
    rd(9'h08e, 8'h7f);
    // Ordinary command cases
    foreach (ROWS[i]) begin
      send('{ROWS[i][39:32], ROWS[i][31:24]});
      chk("group", ROWS[i][15:0], grp[ROWS[i][23:16]]);
    end
    // Last id kept across further data bytes
    send('{8'ha0, 8'h10, 8'h05});
    chk("repeat data", 16'h500a, grp[0]);
    blink(8'h05, 15, 18);
    blink(8'h0d, 7, 10);
    blink(8'h07, 15, 18);
    pin(8'he4, 3'b010, 2'b10);
    pin(8'he0, 3'b101, 2'b11);
    pin(8'he0, 3'b010, 2'b00);
    pin(8'hf3, 3'b000, 2'b10);
    pin(8'hfc, 3'b100, 2'b11);
    pin(8'hf8, 3'b101, 2'b10);
    pin(8'hf0, 3'b000, 2'b00);
    pin(8'hd1, 3'b000, 2'b00);
    pin(8'he8, 3'b000, 2'b01);
    do_reset();
    // Sync acquire after 4 lines, loss after 32 quiet lines
    send('{8'he0, 8'h11});
    sync_on = 1'b1;
    repeat (40) @(negedge i_ref_clk);
    chk("sync early", 16'h0, {15'h0, o_sync_detect});
    repeat (160) @(negedge i_ref_clk);
    chk("sync found", 16'h1, {15'h0, o_sync_detect});
    sync_on = 1'b0;
    repeat (400) @(negedge i_ref_clk);
    chk("sync held", 16'h1, {15'h0, o_sync_detect});
    repeat (400) @(negedge i_ref_clk);
    chk("sync lost", 16'h0, {15'h0, o_sync_detect});
    // Longest codes: acquire after 16 lines, loss after 256
    send('{8'he0, 8'h48});
    sync_on = 1'b1;
    repeat (240) @(negedge i_ref_clk);
    chk("sync slow early", 16'h0, {15'h0, o_sync_detect});
    repeat (200) @(negedge i_ref_clk);
    chk("sync slow found", 16'h1, {15'h0, o_sync_detect});
    sync_on = 1'b0;
    repeat (4800) @(negedge i_ref_clk);
    chk("sync slow held", 16'h1, {15'h0, o_sync_detect});
    repeat (800) @(negedge i_ref_clk);
    chk("sync slow lost", 16'h0, {15'h0, o_sync_detect});
    complete_run();
  end
endmodule // testbench
